// >>> core/rlpc_pin_config.sv
// Configuration registers and pad control for five general-purpose pins, with a second pin set.
// Assumes an AXI4-Lite master on clk_sys, far values already recovered from the link, pads resolved outside.
// Behaviour
// [R1] Second-port select steers the configurations of pins one to three to the matching second-port pin.
// [R2] Local output value drives pin only when enabled, direction output, remote off.
// [R3] Remote enable 1 forces pin output with the serializer's received value.
// [R4] Code direction-then-enable: 00 functional, 10 tri-state, 01 output, 11 input.
// [R5] Pin one settings in bits 0-3, pin two settings in bits 4-7.
// [R6] Pin three register at 1Fh resets to zero; bits 7-4 reserved.
// [R7] Pins five and six register at 20h resets zero; five low, six high.
// [R8] Pins one and two register at 1Eh, reset value zero.
// [R9] After reset every pin is functional output, remote off, value zero.
`timescale 1ns/1ps
`include "rlpc_consts.svh"

module rlpc_pin_config #(
	parameter int NPIN = 5
) (
	input  wire logic                  clk_sys,
	input  wire logic                  rst,
	input  wire logic                  clk_en,
	input  wire logic [7:0]            s_axi_awaddr,
	input  wire logic                  s_axi_awvalid,
	output logic                       s_axi_awready,
	input  wire logic [31:0]           s_axi_wdata,
	input  wire logic [3:0]            s_axi_wstrb,
	input  wire logic                  s_axi_wvalid,
	output logic                       s_axi_wready,
	output logic [1:0]                 s_axi_bresp,
	output logic                       s_axi_bvalid,
	input  wire logic                  s_axi_bready,
	input  wire logic [7:0]            s_axi_araddr,
	input  wire logic                  s_axi_arvalid,
	output logic                       s_axi_arready,
	output logic [31:0]                s_axi_rdata,
	output logic [1:0]                 s_axi_rresp,
	output logic                       s_axi_rvalid,
	input  wire logic                  s_axi_rready,
	input  wire logic [NPIN-1:0]       far_pin_value,
	input  wire logic [NPIN-1:0]       func_pin_out,
	input  wire logic [NPIN-1:0]       pin_in,
	input  wire logic [2:0]            second_port_pin_in,
	output logic [NPIN-1:0]            pin_out,
	output logic [NPIN-1:0]            pin_oe,
	output logic [2:0]                 second_port_pin_out,
	output logic [2:0]                 second_port_pin_oe,
	output logic [NPIN-1:0]            pin_gp_in_value
);

	// Pin order in vectors: 0=pin1, 1=pin2, 2=pin3, 3=pin5, 4=pin6
	rlpc_pkg::rlpc_pin_cfg_t           cfg_q [NPIN];
	logic                              second_port_select_q;
	logic [7:0]                        aw_addr_q;
	logic                              aw_have_q;
	logic [31:0]                       w_data_q;
	logic [3:0]                        w_strb_q;
	logic                              w_have_q;
	logic [NPIN-1:0]                   gp_in_q;
	rlpc_pkg::rlpc_pad_t               pad_w [NPIN];

	function automatic rlpc_pkg::rlpc_mode_t decode_mode(input rlpc_pkg::rlpc_pin_cfg_t c);
		unique case ({c.direction, c.function_enable}) // [R4]
			2'b00: decode_mode = rlpc_pkg::RLPC_FUNC_OUT;
			2'b10: decode_mode = rlpc_pkg::RLPC_TRISTATE;
			2'b01: decode_mode = rlpc_pkg::RLPC_GP_OUT;
			2'b11: decode_mode = rlpc_pkg::RLPC_GP_IN;
		endcase
	endfunction : decode_mode

	function automatic rlpc_pkg::rlpc_pad_t pad_drive(input rlpc_pkg::rlpc_pin_cfg_t c,
		input logic far_v, input logic func_v);
		rlpc_pkg::rlpc_pad_t p;
		p = '{out: 1'b0, oe: 1'b0};
		if (c.far_control_enable) begin
			p = '{out: far_v, oe: 1'b1}; // [R3]
		end else begin
			unique case (decode_mode(c))
				rlpc_pkg::RLPC_FUNC_OUT: p = '{out: func_v, oe: 1'b1};
				rlpc_pkg::RLPC_GP_OUT:   p = '{out: c.local_out_value, oe: 1'b1}; // [R2]
				rlpc_pkg::RLPC_TRISTATE: p = '{out: 1'b0, oe: 1'b0};
				rlpc_pkg::RLPC_GP_IN:    p = '{out: 1'b0, oe: 1'b0};
			endcase
		end
		pad_drive = p;
	endfunction : pad_drive

	logic                              wr_fire;
	logic                              rd_fire;
	assign wr_fire = aw_have_q && w_have_q && !s_axi_bvalid;
	assign rd_fire = s_axi_arvalid && s_axi_arready;

	// Write address and data are latched independently so either may come first
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			aw_have_q     <= 1'b0;
			w_have_q      <= 1'b0;
			aw_addr_q     <= 8'h00;
			w_data_q      <= 32'h0000_0000;
			w_strb_q      <= 4'h0;
			s_axi_awready <= 1'b0;
			s_axi_wready  <= 1'b0;
		end else if (clk_en) begin
			s_axi_awready <= !aw_have_q && !(s_axi_awvalid && s_axi_awready) && !wr_fire;
			s_axi_wready  <= !w_have_q && !(s_axi_wvalid && s_axi_wready) && !wr_fire;
			if (s_axi_awvalid && s_axi_awready) begin
				aw_have_q <= 1'b1;
				aw_addr_q <= s_axi_awaddr;
			end else if (wr_fire) begin
				aw_have_q <= 1'b0;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				w_have_q <= 1'b1;
				w_data_q <= s_axi_wdata;
				w_strb_q <= s_axi_wstrb;
			end else if (wr_fire) begin
				w_have_q <= 1'b0;
			end
		end
	end

	// Write response; unmapped addresses answer SLVERR and change nothing
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			s_axi_bvalid <= 1'b0;
			s_axi_bresp  <= 2'b00;
		end else if (clk_en) begin
			if (wr_fire) begin
				s_axi_bvalid <= 1'b1;
				unique case (aw_addr_q)
					`RLPC_OFS_PINS1_2, `RLPC_OFS_PIN3, `RLPC_OFS_PINS5_6, `RLPC_OFS_PORT_CTRL,
					`RLPC_OFS_PIN_STATUS: s_axi_bresp <= 2'b00;
					default:              s_axi_bresp <= 2'b10;
				endcase
			end else if (s_axi_bready) begin
				s_axi_bvalid <= 1'b0;
			end
		end
	end

	// Register storage; only byte lane 0 carries data
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			for (int i = 0; i < NPIN; i++) begin
				cfg_q[i] <= rlpc_pkg::rlpc_pin_cfg_t'(4'h0); // [R6] [R7] [R8] [R9]
			end
			second_port_select_q <= `RLPC_RST_PORT_CTRL;
		end else if (clk_en && wr_fire && w_strb_q[0]) begin
			unique case (aw_addr_q)
				`RLPC_OFS_PINS1_2: begin
					cfg_q[0] <= w_data_q[3:0]; // [R5]
					cfg_q[1] <= w_data_q[7:4]; // [R5]
				end
				`RLPC_OFS_PIN3: cfg_q[2] <= w_data_q[3:0]; // [R6]
				`RLPC_OFS_PINS5_6: begin
					cfg_q[3] <= w_data_q[3:0]; // [R7]
					cfg_q[4] <= w_data_q[7:4]; // [R7]
				end
				`RLPC_OFS_PORT_CTRL: second_port_select_q <= w_data_q[`RLPC_FLD_PORTSEL];
				default: ;
			endcase
		end
	end

	// Read channel, one request at a time
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid  <= 1'b0;
			s_axi_rdata   <= 32'h0000_0000;
			s_axi_rresp   <= 2'b00;
		end else if (clk_en) begin
			s_axi_arready <= !s_axi_rvalid && !rd_fire;
			if (rd_fire) begin
				s_axi_rvalid <= 1'b1;
				s_axi_rresp  <= 2'b00;
				unique case (s_axi_araddr)
					`RLPC_OFS_PINS1_2:    s_axi_rdata <= {24'h000000, cfg_q[1], cfg_q[0]};
					// Reserved nibble is not stored and reads zero
					`RLPC_OFS_PIN3:       s_axi_rdata <= {28'h0000000, cfg_q[2]}; // [R6]
					`RLPC_OFS_PINS5_6:    s_axi_rdata <= {24'h000000, cfg_q[4], cfg_q[3]};
					`RLPC_OFS_PORT_CTRL:  s_axi_rdata <= {31'h00000000, second_port_select_q};
					`RLPC_OFS_PIN_STATUS: s_axi_rdata <= {27'h0000000, gp_in_q};
					default: begin
						s_axi_rdata <= 32'h0000_0000;
						s_axi_rresp <= 2'b10;
					end
				endcase
			end else if (s_axi_rready) begin
				s_axi_rvalid <= 1'b0;
			end
		end
	end

	// Drive worked out per pin ahead of the pad flops
	always_comb begin
		for (int i = 0; i < NPIN; i++) begin
			pad_w[i] = pad_drive(cfg_q[i], far_pin_value[i], func_pin_out[i]); // [R2] [R3]
		end
	end

	// Pad outputs registered; unselected pin set is released to tri-state
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			pin_out             <= '0;
			pin_oe              <= '0;
			second_port_pin_out <= 3'h0;
			second_port_pin_oe  <= 3'h0;
		end else if (clk_en) begin
			for (int i = 0; i < NPIN; i++) begin
				pin_out[i] <= pad_w[i].out;
				pin_oe[i]  <= pad_w[i].oe;
			end
			// Only pins 1 to 3 have a second-port twin; the later assignment wins
			for (int i = 0; i < 3; i++) begin
				if (second_port_select_q) begin // [R1]
					pin_out[i]             <= 1'b0;
					pin_oe[i]              <= 1'b0;
					second_port_pin_out[i] <= pad_w[i].out;
					second_port_pin_oe[i]  <= pad_w[i].oe;
				end else begin
					second_port_pin_out[i] <= 1'b0;
					second_port_pin_oe[i]  <= 1'b0;
				end
			end
		end
	end

	// Input sample follows the selected pin set for pins 1 to 3
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			gp_in_q <= '0;
		end else if (clk_en) begin
			for (int i = 0; i < NPIN; i++) begin
				gp_in_q[i] <= pin_in[i];
			end
			for (int i = 0; i < 3; i++) begin
				if (second_port_select_q) begin
					gp_in_q[i] <= second_port_pin_in[i]; // [R1]
				end
			end
		end
	end

	assign pin_gp_in_value = gp_in_q;

endmodule : rlpc_pin_config

// >>> core/rlpc_consts.svh
// Register offsets, field positions and reset values of the pin configuration block.
// Assumes a 32-bit AXI4-Lite bus, one register per aligned word at four times its index.
`ifndef RLPC_CONSTS_SVH
`define RLPC_CONSTS_SVH

`define RLPC_IDX_PINS1_2      8'h1E
`define RLPC_IDX_PIN3         8'h1F
`define RLPC_IDX_PINS5_6      8'h20
`define RLPC_IDX_PORT_CTRL    8'h24
`define RLPC_IDX_PIN_STATUS   8'h28

// Byte addresses: the indices are not word aligned, so each word sits at four times its index
`define RLPC_OFS_PINS1_2      (`RLPC_IDX_PINS1_2 << 2)
`define RLPC_OFS_PIN3         (`RLPC_IDX_PIN3 << 2)
`define RLPC_OFS_PINS5_6      (`RLPC_IDX_PINS5_6 << 2)
`define RLPC_OFS_PORT_CTRL    (`RLPC_IDX_PORT_CTRL << 2)
`define RLPC_OFS_PIN_STATUS   (`RLPC_IDX_PIN_STATUS << 2)

`define RLPC_FLD_EN           0
`define RLPC_FLD_DIR          1
`define RLPC_FLD_FAR          2
`define RLPC_FLD_VAL          3
`define RLPC_FLD_PORTSEL      0

`define RLPC_RST_CFG          8'h00
`define RLPC_RST_PORT_CTRL    1'b0

`endif

// >>> core/rlpc_pkg.sv
// Types shared by the pin configuration block.
// Assumes the constants header is included where offsets are needed.
package rlpc_pkg;

	typedef enum logic [3:0] {
		RLPC_FUNC_OUT = 4'h1,
		RLPC_TRISTATE = 4'h2,
		RLPC_GP_OUT   = 4'h4,
		RLPC_GP_IN    = 4'h8
	} rlpc_mode_t;

	typedef struct packed {
		logic local_out_value;
		logic far_control_enable;
		logic direction;
		logic function_enable;
	} rlpc_pin_cfg_t;

	typedef struct packed {
		logic out;
		logic oe;
	} rlpc_pad_t;

endpackage : rlpc_pkg

// >>> verif/rlpc_far_model.sv
// Remote serializer stand-in forwarding pin values over the link.
// Assumes the bench sets the pattern; the link adds one cycle.
`timescale 1ns/1ps
module rlpc_far_model #(parameter int NPIN = 5) (
	input  wire logic            clk_sys,
	input  wire logic            rst,
	input  wire logic [NPIN-1:0] pattern,
	output logic      [NPIN-1:0] far_pin_value
);
	// Nothing is forwarded until the link is out of reset
	always_ff @(posedge clk_sys) begin
		if (rst) far_pin_value <= '0;
		else far_pin_value <= pattern;
	end
endmodule : rlpc_far_model

// >>> verif/rlpc_pin_config_props.sv
// Checker on the bus and pad ports of the pin configuration block.
// Assumes clk_en stays high while bus traffic is under way.
`timescale 1ns/1ps
module rlpc_pin_config_props #(
	parameter int NPIN = 5
) (
	input wire logic            clk_sys,
	input wire logic            rst,
	input wire logic            s_axi_awvalid,
	input wire logic            s_axi_awready,
	input wire logic            s_axi_wvalid,
	input wire logic            s_axi_wready,
	input wire logic            s_axi_bvalid,
	input wire logic            s_axi_bready,
	input wire logic            s_axi_arvalid,
	input wire logic            s_axi_arready,
	input wire logic            s_axi_rvalid,
	input wire logic            s_axi_rready,
	input wire logic [1:0]      s_axi_bresp,
	input wire logic [31:0]     s_axi_rdata,
	input wire logic [NPIN-1:0] pin_oe,
	input wire logic [2:0]      second_port_pin_oe
);
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (rst);
	sequence wr_taken; s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready; endsequence
	sequence rd_taken; s_axi_arvalid && s_axi_arready; endsequence
	// Address and data are latched first, the response follows one cycle later
	a_write_answer: assert property (wr_taken |-> ##2 s_axi_bvalid) else $error("no bvalid");
	a_read_answer: assert property (rd_taken |=> s_axi_rvalid) else $error("no rvalid");
	a_bresp_once: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid) else $error("bvalid repeated");
	a_rresp_once: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid) else $error("rvalid repeated");
	a_rdata_upper: assert property (s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h000000) else $error("upper bits");
	a_bresp_legal: assert property (s_axi_bvalid |-> !s_axi_bresp[0]) else $error("bad bresp");
	a_port_exclusive: assert property (!(|(pin_oe[2:0] & second_port_pin_oe))) else $error("both sets");
	a_reset_idle: assert property ($past(rst) |-> !s_axi_bvalid && pin_oe == '0) else $error("not idle");
endmodule : rlpc_pin_config_props

bind rlpc_pin_config rlpc_pin_config_props #(.NPIN(NPIN)) rlpc_pin_config_props_inst (
	.clk_sys(clk_sys), .rst(rst), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
	.s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bvalid(s_axi_bvalid),
	.s_axi_bready(s_axi_bready), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
	.s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .s_axi_bresp(s_axi_bresp),
	.s_axi_rdata(s_axi_rdata), .pin_oe(pin_oe), .second_port_pin_oe(second_port_pin_oe));

// >>> verif/rlpc_pin_config_tb.sv
// Bench: register writes, pad checks, refusals and port select.
// Assumes one bus request at a time; a cycle ceiling cuts hangs short.
`timescale 1ns/1ps
`include "rlpc_consts.svh"
module rlpc_pin_config_tb;
	typedef struct {logic [7:0] c12, c3, c56; logic [4:0] fn, far, eo, eoe;} rlpc_row_t;
	rlpc_row_t rows [2] = '{'{8'h20, 8'hF9, 8'h73, 5'h01, 5'h10, 5'h15, 5'h15},
		'{8'hC1, 8'h02, 8'h90, 5'h08, 5'h00, 5'h18, 5'h1B}};
	logic [7:0] ofs [3] = '{`RLPC_OFS_PINS1_2, `RLPC_OFS_PIN3, `RLPC_OFS_PINS5_6};
	logic clk_sys = 1'b0, rst = 1'b1, clk_en = 1'b1, s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0;
	logic s_axi_bready = 1'b0, s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
	logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, ta, tw, tv;
	logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
	logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, d;
	logic [3:0] s_axi_wstrb = 4'h0;
	logic [1:0] s_axi_bresp, s_axi_rresp, r;
	logic [4:0] func_pin_out = 5'h00, pat = 5'h00, pin_in = 5'h0A, far_pin_value, pin_out, pin_oe, pin_gp_in_value;
	logic [2:0] second_port_pin_in = 3'h5, second_port_pin_out, second_port_pin_oe;
	int errors = 0, check_count = 0, cyc = 0;
	rlpc_pin_config #(.NPIN(5)) rlpc_pin_config_inst (.*);
	rlpc_far_model #(.NPIN(5)) rlpc_far_model_inst (.*, .pattern(pat));
	always #2.5 clk_sys = ~clk_sys;
	always @(posedge clk_sys) begin
		cyc <= cyc + 1;
		if (cyc == 2000) begin
			errors++;
			test_done();
		end
	end
	task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
		check_count++;
		if (g !== e) begin
			errors++;
			$display("BAD %s expected %h seen %h", n, e, g);
		end
	endtask : chk
	// Ready flags are sampled mid-cycle, where they equal what the next edge sees
	task automatic wr(input logic [7:0] a, input logic [7:0] v, input logic [3:0] s);
		@(posedge clk_sys);
		s_axi_awaddr <= a;
		s_axi_wdata <= {24'h000000, v};
		s_axi_wstrb <= s;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		tv = 1'b0;
		while (!tv) begin
			@(negedge clk_sys);
			ta = s_axi_awready;
			tw = s_axi_wready;
			tv = s_axi_bvalid;
			r = s_axi_bresp;
			@(posedge clk_sys);
			if (ta) s_axi_awvalid <= 1'b0;
			if (tw) s_axi_wvalid <= 1'b0;
		end
		s_axi_bready <= 1'b0;
	endtask : wr
	task automatic rd(input logic [7:0] a);
		@(posedge clk_sys);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		tv = 1'b0;
		while (!tv) begin
			@(negedge clk_sys);
			ta = s_axi_arready;
			tv = s_axi_rvalid;
			d = s_axi_rdata;
			r = s_axi_rresp;
			@(posedge clk_sys);
			if (ta) s_axi_arvalid <= 1'b0;
		end
		s_axi_rready <= 1'b0;
	endtask : rd
	task automatic test_done;
		$display("checks %0d mismatches %0d", check_count, errors);
		if (errors == 0 && check_count > 0) $display("Finished cleanly");
		else $display("Finished with errors");
		$finish;
	endtask : test_done
	initial begin
		repeat (5) @(posedge clk_sys);
		rst <= 1'b0;
		repeat (3) @(negedge clk_sys);
		chk("oe_rst", 32'h1F, 32'(pin_oe));
		chk("out_rst", 32'h0, 32'(pin_out));
		foreach (ofs[i]) begin
			rd(ofs[i]);
			chk("cfg_rst", 32'h0, d);
		end
		foreach (rows[i]) begin
			wr(ofs[0], rows[i].c12, 4'h1);
			wr(ofs[1], rows[i].c3, 4'h1);
			wr(ofs[2], rows[i].c56, 4'h1);
			func_pin_out <= rows[i].fn;
			pat <= rows[i].far;
			repeat (4) @(negedge clk_sys);
			chk("pin_oe", 32'(rows[i].eoe), 32'(pin_oe));
			chk("pin_out", 32'(rows[i].eo), 32'(pin_out & rows[i].eoe));
			rd(ofs[0]);
			chk("cfg12", 32'(rows[i].c12), d);
			rd(ofs[1]);
			chk("cfg3", 32'(rows[i].c3 & 8'h0F), d);
			rd(ofs[2]);
			chk("cfg56", 32'(rows[i].c56), d);
		end
		wr(ofs[2], 8'hFF, 4'h0);
		rd(ofs[2]);
		chk("no_strobe", 32'h90, d);
		wr(8'h40, 8'hFF, 4'h1);
		chk("bad_wr", 32'h2, 32'(r));
		rd(8'h40);
		chk("bad_rd", 32'h2, 32'(r));
		@(negedge clk_sys);
		chk("gp_in", 32'h0A, 32'(pin_gp_in_value));
		rd(`RLPC_OFS_PIN_STATUS);
		chk("status", 32'h0A, d);
		pat <= 5'h02;
		wr(`RLPC_OFS_PORT_CTRL, 8'h01, 4'h1);
		repeat (4) @(negedge clk_sys);
		chk("sp_oe", 32'h3, 32'(second_port_pin_oe));
		chk("sp_out", 32'h2, 32'(second_port_pin_out & second_port_pin_oe));
		chk("oe_sel", 32'h18, 32'(pin_oe));
		chk("gp_in_sel", 32'h0D, 32'(pin_gp_in_value));
		// Clock enable low must freeze the pads although the far value moves
		@(posedge clk_sys);
		clk_en <= 1'b0;
		pat <= 5'h00;
		repeat (4) @(negedge clk_sys);
		chk("sp_out_held", 32'h2, 32'(second_port_pin_out));
		@(posedge clk_sys);
		clk_en <= 1'b1;
		repeat (3) @(negedge clk_sys);
		chk("sp_out_run", 32'h0, 32'(second_port_pin_out));
		@(posedge clk_sys);
		rst <= 1'b1;
		@(posedge clk_sys);
		rst <= 1'b0;
		repeat (3) @(negedge clk_sys);
		chk("oe_rst2", 32'h1F, 32'(pin_oe));
		chk("out_rst2", 32'h08, 32'(pin_out));
		chk("sp_oe_rst2", 32'h0, 32'(second_port_pin_oe));
		test_done();
	end
endmodule : rlpc_pin_config_tb
